// ==== design/pgm_pkg.sv ====
// Shared constants and types of the power-good monitor
package pgm_pkg;

  // Bus geometry
  localparam int unsigned PGM_ADDR_W  = 10;
  localparam int unsigned PGM_DATA_W  = 32;
  localparam int unsigned PGM_NUM_SRC = 4;
  localparam int unsigned PGM_IRQ_W   = 3;

  // Register indices, byte address is four times the index
  localparam logic [7:0] PGM_IDX_SOURCE_CFG  = 8'h15;
  localparam logic [7:0] PGM_IDX_MODE_CFG    = 8'h16;
  localparam logic [7:0] PGM_IDX_FAULT_LATCH = 8'h17;
  localparam logic [7:0] PGM_IDX_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] PGM_IDX_IRQ_ENABLE  = 8'h21;
  localparam logic [7:0] PGM_IDX_IRQ_CLEAR   = 8'h22;
  localparam logic [7:0] PGM_IDX_LIVE_STATUS = 8'h23;

  // Source configuration fields
  localparam int unsigned PGM_POL_BIT     = 7;
  localparam int unsigned PGM_OD_BIT      = 6;
  localparam int unsigned PGM_LIN_WIN_BIT = 5;
  localparam int unsigned PGM_SW_WIN_BIT  = 4;
  localparam int unsigned PGM_SEL_LSB     = 0;

  // Mode configuration fields
  localparam int unsigned PGM_TWARN_BIT   = 2;
  localparam int unsigned PGM_FGATE_BIT   = 1;
  localparam int unsigned PGM_OPMODE_BIT  = 0;

  // Interrupt status bits
  localparam int unsigned PGM_IRQ_DROP    = 0;
  localparam int unsigned PGM_IRQ_FAULT   = 1;
  localparam int unsigned PGM_IRQ_RISE    = 2;

  // Sources 3 and 2 are linear regulators, 1 and 0 switchers
  localparam logic [3:0] PGM_LINEAR_MASK = 4'hC;

  // Values after reset
  localparam logic [7:0] PGM_SOURCE_CFG_RST = 8'h00;
  localparam logic [7:0] PGM_MODE_CFG_RST   = 8'h00;
  localparam logic [3:0] PGM_FAULT_RST      = 4'h0;
  localparam logic [2:0] PGM_IRQ_EN_RST     = 3'h0;

  typedef enum logic [1:0] {
    PGM_APB_IDLE   = 2'b01,
    PGM_APB_ANSWER = 2'b10
  } pgm_apb_state_type;

endpackage : pgm_pkg

// ==== design/pgm_source_eval.sv ====
// Per-source voltage window evaluation of the power-good monitor
module pgm_source_eval
  import pgm_pkg::*;
#(
  parameter int unsigned NUM_SRC = PGM_NUM_SRC
) (
  // Comparator levels, one bit per regulator
  input  wire logic [NUM_SRC-1:0] uv_ok,
  input  wire logic [NUM_SRC-1:0] ov_ok,
  // Configuration
  input  wire logic [NUM_SRC-1:0] linear_mask,
  input  wire logic               linear_window_check,
  input  wire logic               switcher_window_check,
  input  wire logic [NUM_SRC-1:0] select,
  // Results
  output logic      [NUM_SRC-1:0] src_valid,
  output logic                    all_valid
);

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      logic window;
      assign window = linear_mask[i] ? linear_window_check : switcher_window_check;
      // Undervoltage always, overvoltage only in window mode
      assign src_valid[i] = uv_ok[i] & (ov_ok[i] | ~window);
    end
  endgenerate

  // Every selected source must be valid at once
  assign all_valid = &(src_valid | ~select);

endmodule : pgm_source_eval

// ==== design/pgm_irq.sv ====
// Sticky interrupt status with enable and write-one clear
module pgm_irq
  import pgm_pkg::*;
#(
  parameter int unsigned W = PGM_IRQ_W
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Events and software access
  input  wire logic [W-1:0] event_set,
  input  wire logic         enable_wr,
  input  wire logic         clear_wr,
  input  wire logic [W-1:0] wdata,
  // State
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] enable;
    logic         irq;
  } pgm_irq_state_type;

  pgm_irq_state_type q;
  pgm_irq_state_type n;

  always_comb begin
    n = q;
    if (ce) begin
      // A new event wins over a clear in the same cycle
      n.status = (q.status & ~(clear_wr ? wdata : '0)) | event_set;
      if (enable_wr) begin
        n.enable = wdata;
      end
      n.irq = |(n.status & n.enable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{status: '0, enable: W'(PGM_IRQ_EN_RST), irq: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign status = q.status;
  assign enable = q.enable;
  assign irq    = q.irq;

endmodule : pgm_irq

// ==== design/pgm_top.sv ====
// Power-good monitor: source aggregation, fault latch, pin drive and APB registers

// Overview of operation
// - Pin is high when valid with polarity 0, low when valid with polarity 1.
// - Pin drive is push-pull with drive-type 0, open-drain with drive-type 1.
// - Linear sources check undervoltage only, or both limits when window bit set.
// - Switcher sources check undervoltage only, or both limits when window bit set.
// - Each regulator counts toward power-good only when its select bit is 1.
// - With thermal select set, an active thermal warning forces power-good inactive.
// - Fault-gating 0 follows live status; 1 follows the fault latch register.
// - Operating mode bit: 0 gated mode, 1 continuous mode.
// - A selected regulator that drops power-good sets its fault latch bit, except in gated mode while the regulators are stopped.
// - Writing one clears a fault latch bit, only while that regulator is valid.
// - A fault latch bit reads 0 unless its regulator dropped power-good since clear.
// - Power-good falling from active to inactive sets a sticky write-one-clear flag.
module pgm_top
  import pgm_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PGM_ADDR_W-1:0] paddr,
  input  wire logic [PGM_DATA_W-1:0] pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic      [PGM_DATA_W-1:0] prdata,
  output logic                       pslverr,
  // Regulator monitors and thermal warning
  input  wire logic [3:0]            uv_ok,
  input  wire logic [3:0]            ov_ok,
  input  wire logic                  thermal_warn,
  input  wire logic                  regulators_active,
  // Power-good pin and interrupt
  output logic                       power_ok_out,
  output logic                       power_ok_out_en,
  output logic                       irq
);

  typedef struct packed {
    logic [7:0]        source_cfg;
    logic [7:0]        mode_cfg;
    logic [3:0]        fault;
    logic              active;
    logic              out_level;
    logic              out_en;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    pgm_apb_state_type apb_state;
  } pgm_top_state_type;

  localparam pgm_top_state_type RESET_STATE = '{
    source_cfg: PGM_SOURCE_CFG_RST,
    mode_cfg:   PGM_MODE_CFG_RST,
    fault:      PGM_FAULT_RST,
    active:     1'b0,
    out_level:  1'b0,
    out_en:     1'b1,
    pready:     1'b0,
    pslverr:    1'b0,
    prdata:     32'h0000_0000,
    apb_state:  PGM_APB_IDLE
  };

  pgm_top_state_type q;
  pgm_top_state_type n;

  logic [3:0]           select;
  logic [3:0]           src_valid;
  logic                 all_valid;
  logic [7:0]           idx;
  logic                 aligned;
  logic                 wr_fire;
  logic [3:0]           fault_clr;
  logic [3:0]           fault_events;
  logic                 gate_ok;
  logic                 twarn_block;
  logic                 fault_ok;
  logic                 pin_level;
  logic [PGM_IRQ_W-1:0] irq_events;
  logic [PGM_IRQ_W-1:0] irq_status;
  logic [PGM_IRQ_W-1:0] irq_enable;
  logic                 irq_en_wr;
  logic                 irq_clr_wr;

  assign select  = q.source_cfg[PGM_SEL_LSB +: 4];
  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr_fire = ce && psel && penable && q.pready && pwrite && pstrb[0] && aligned;

  pgm_source_eval #(
    .NUM_SRC (PGM_NUM_SRC)
  ) u_eval (
    .uv_ok                 (uv_ok),
    .ov_ok                 (ov_ok),
    .linear_mask           (PGM_LINEAR_MASK),
    .linear_window_check   (q.source_cfg[PGM_LIN_WIN_BIT]),
    .switcher_window_check (q.source_cfg[PGM_SW_WIN_BIT]),
    .select                (select),
    .src_valid             (src_valid),
    .all_valid             (all_valid)
  );

  // Gated mode evaluates only while the regulators run
  assign gate_ok     = q.mode_cfg[PGM_OPMODE_BIT] | regulators_active;
  assign twarn_block = q.mode_cfg[PGM_TWARN_BIT] & thermal_warn;
  // Selected failing sources become faults only while evaluation runs
  assign fault_events = select & ~src_valid & {4{gate_ok}};
  assign fault_ok     = ~|(q.fault | fault_events);
  // Clear honoured only for a valid source
  assign fault_clr = (wr_fire && idx == PGM_IDX_FAULT_LATCH) ? (pwdata[3:0] & src_valid)
                                                           : 4'h0;
  assign irq_en_wr  = wr_fire && (idx == PGM_IDX_IRQ_ENABLE);
  assign irq_clr_wr = wr_fire && (idx == PGM_IDX_IRQ_CLEAR);

  always_comb begin
    n         = q;
    pin_level = 1'b0;
    irq_events = '0;
    if (ce) begin
      // Fault latch: set wins over clear
      n.fault = (q.fault & ~fault_clr) | fault_events;
      // Live or latched view, thermal and gating applied
      n.active = gate_ok && !twarn_block &&
                 (q.mode_cfg[PGM_FGATE_BIT] ? fault_ok : all_valid);
      pin_level = n.active ^ q.source_cfg[PGM_POL_BIT];
      if (q.source_cfg[PGM_OD_BIT]) begin
        n.out_level = 1'b0;
        n.out_en    = ~pin_level;
      end else begin
        n.out_level = pin_level;
        n.out_en    = 1'b1;
      end
      irq_events[PGM_IRQ_DROP]  = q.active & ~n.active;
      irq_events[PGM_IRQ_RISE]  = ~q.active & n.active;
      irq_events[PGM_IRQ_FAULT] = |(fault_events & ~q.fault);
      unique case (q.apb_state)
        PGM_APB_IDLE: begin
          n.pready  = 1'b0;
          n.pslverr = 1'b0;
          if (psel && !penable) begin
            n.pready    = 1'b1;
            n.apb_state = PGM_APB_ANSWER;
            n.prdata    = 32'h0000_0000;
            n.pslverr   = 1'b0;
            if (!aligned) begin
              n.pslverr = 1'b1;
            end else begin
              unique case (idx)
                PGM_IDX_SOURCE_CFG:  n.prdata[7:0] = q.source_cfg;
                PGM_IDX_MODE_CFG:    n.prdata[7:0] = q.mode_cfg;
                PGM_IDX_FAULT_LATCH: n.prdata[3:0] = q.fault;
                PGM_IDX_IRQ_STATUS:  n.prdata[PGM_IRQ_W-1:0] = irq_status;
                PGM_IDX_IRQ_ENABLE:  n.prdata[PGM_IRQ_W-1:0] = irq_enable;
                PGM_IDX_IRQ_CLEAR:   n.prdata = 32'h0000_0000;
                PGM_IDX_LIVE_STATUS: n.prdata[5:0] = {q.active, thermal_warn, src_valid};
                default:             n.pslverr = 1'b1;
              endcase
            end
          end
        end
        PGM_APB_ANSWER: begin
          if (psel && penable) begin
            n.pready    = 1'b0;
            n.pslverr   = 1'b0;
            n.apb_state = PGM_APB_IDLE;
            if (wr_fire && idx == PGM_IDX_SOURCE_CFG) begin
              n.source_cfg = pwdata[7:0];
            end
            if (wr_fire && idx == PGM_IDX_MODE_CFG) begin
              n.mode_cfg = pwdata[7:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  pgm_irq #(
    .W (PGM_IRQ_W)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .event_set (irq_events),
    .enable_wr (irq_en_wr),
    .clear_wr  (irq_clr_wr),
    .wdata     (pwdata[PGM_IRQ_W-1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  assign pready          = q.pready;
  assign prdata          = q.prdata;
  assign pslverr         = q.pslverr;
  assign power_ok_out    = q.out_level;
  assign power_ok_out_en = q.out_en;

  AST_PUSH_PULL_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (!q.source_cfg[PGM_OD_BIT] && $stable(q.source_cfg) && $past(ce))
      |-> power_ok_out_en && (power_ok_out == (q.active ^ q.source_cfg[PGM_POL_BIT])))
    else $error("Push-pull pin level does not match power-good and polarity");

  AST_OPEN_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
    (q.source_cfg[PGM_OD_BIT] && $stable(q.source_cfg) && $past(ce))
      |-> !power_ok_out && (power_ok_out_en == !(q.active ^ q.source_cfg[PGM_POL_BIT])))
    else $error("Open-drain pin drives high or releases at the wrong level");

  AST_LINEAR_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
    src_valid[3:2] == (uv_ok[3:2] & (ov_ok[3:2] | {2{!q.source_cfg[PGM_LIN_WIN_BIT]}})))
    else $error("Linear source validity ignores the window setting");

  AST_SWITCHER_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
    src_valid[1:0] == (uv_ok[1:0] & (ov_ok[1:0] | {2{!q.source_cfg[PGM_SW_WIN_BIT]}})))
    else $error("Switcher source validity ignores the window setting");

  AST_ALL_SELECTED_VALID: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && gate_ok && !twarn_block && !q.mode_cfg[PGM_FGATE_BIT] &&
     ((select & ~src_valid) == 4'h0)) |=> q.active)
    else $error("Power-good stays inactive with every selected source valid");

  AST_ANY_SELECTED_FAILS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ((select & ~src_valid) != 4'h0)) |=> !q.active)
    else $error("Power-good active while a selected source fails");

  AST_THERMAL_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && q.mode_cfg[PGM_TWARN_BIT] && thermal_warn) |=> !q.active)
    else $error("Thermal warning did not force power-good inactive");

  AST_FAULT_GATING: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && q.mode_cfg[PGM_FGATE_BIT] && q.fault != 4'h0) |=> !q.active)
    else $error("Power-good active while a latched fault stands");

  AST_GATED_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !q.mode_cfg[PGM_OPMODE_BIT] && !regulators_active) |=> !q.active)
    else $error("Gated mode reported power-good with regulators stopped");

  AST_FAULT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fault_events != 4'h0) |=> ((q.fault & $past(fault_events)) == $past(fault_events)))
    else $error("Failing selected source did not set its fault latch");

  AST_CLEAR_NEEDS_VALID: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && (q.fault & ~src_valid) != 4'h0)
      |=> ((q.fault & $past(q.fault & ~src_valid)) == $past(q.fault & ~src_valid)))
    else $error("Fault latch cleared while its source is invalid");

  AST_FAULT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fault == 4'h0 && fault_events == 4'h0) |=> q.fault == 4'h0)
    else $error("Fault latch set without a failing selected source");

  AST_DROP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && q.active && !n.active) |=> irq_status[PGM_IRQ_DROP] ##1 1'b1)
    else $error("Power-good drop did not set the drop flag");

endmodule : pgm_top

// ==== test/pgm_pin_reader.sv ====
// Model of the system logic that reads the power-good pin through a pull-up
module pgm_pin_reader (
  // Pin as driven by the monitor
  input  wire logic power_ok_out,
  input  wire logic power_ok_out_en,
  // Level seen by the reader
  output wire logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Undriven open-drain pin is pulled high by the board
  assign pin_level = power_ok_out_en ? power_ok_out : 1'b1;
endmodule : pgm_pin_reader

// ==== test/power_good_monitor_test.sv ====
// Self-checking testbench of the power-good monitor
module power_good_monitor_test
  import pgm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [PGM_ADDR_W-1:0] paddr = '0;
  logic [PGM_DATA_W-1:0] pwdata = '0;
  logic [3:0]            pstrb = 4'hF;
  logic [1:0]            pofs = 2'b00;
  logic                  ce = 1'b1;
  logic                  pready;
  logic [PGM_DATA_W-1:0] prdata;
  logic                  pslverr;
  logic [3:0]            uv_ok = 4'hF;
  logic [3:0]            ov_ok = 4'hF;
  logic                  thermal_warn = 1'b0;
  logic                  regulators_active = 1'b1;
  logic                  power_ok_out;
  logic                  power_ok_out_en;
  logic                  irq;
  wire logic             pin_level;
  logic [31:0]           rd;
  logic                  err;
  int                    n_mismatch = 0;
  int                    check_count = 0;
  int                    cycles = 0;

  always #5 pclk = ~pclk;

  pgm_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .uv_ok(uv_ok), .ov_ok(ov_ok),
    .thermal_warn(thermal_warn), .regulators_active(regulators_active),
    .power_ok_out(power_ok_out), .power_ok_out_en(power_ok_out_en), .irq(irq));

  pgm_pin_reader reader (.power_ok_out(power_ok_out), .power_ok_out_en(power_ok_out_en),
    .pin_level(pin_level));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; answer is taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, pofs};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle

  task automatic set_uv(input logic [3:0] v);
    @(posedge pclk);
    uv_ok <= v;
    settle();
  endtask : set_uv

  task automatic clear_all();
    apb(1'b1, PGM_IDX_FAULT_LATCH, 8'h0F);
    apb(1'b1, PGM_IDX_IRQ_CLEAR, 8'h07);
  endtask : clear_all

  task automatic t_reset();
    apb(1'b0, PGM_IDX_SOURCE_CFG, 8'h00);
    chk(rd, 32'h0, "source cfg reset");
    apb(1'b0, PGM_IDX_MODE_CFG, 8'h00);
    chk(rd, 32'h0, "mode cfg reset");
    apb(1'b0, PGM_IDX_FAULT_LATCH, 8'h00);
    chk(rd, 32'h0, "fault latch reset");
    apb(1'b0, 8'h30, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, PGM_IDX_SOURCE_CFG, 8'h0F);
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h01);
    apb(1'b0, PGM_IDX_MODE_CFG, 8'h00);
    chk(rd, 32'h1, "mode cfg readback");
  endtask : t_reset

  task automatic t_pin();
    logic pol;
    logic od;
    for (int i = 0; i < 4; i++) begin
      pol = i[0];
      od  = i[1];
      apb(1'b1, PGM_IDX_SOURCE_CFG, {pol, od, 6'h0F});
      settle();
      chk(pin_level, !pol, "pin valid");
      chk(power_ok_out_en, od ? pol : 1'b1, "pin enable valid");
      set_uv(4'hE);
      chk(pin_level, pol, "pin invalid");
      chk(power_ok_out_en, od ? !pol : 1'b1, "pin enable invalid");
      set_uv(4'hF);
    end
    apb(1'b1, PGM_IDX_SOURCE_CFG, 8'h0F);
    clear_all();
  endtask : t_pin

  task automatic t_window();
    logic lin;
    logic sw;
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      ov_ok <= ~(4'h1 << i);
      for (int w = 0; w < 3; w++) begin
        lin = (w == 1 && i >= 2) || (w == 2 && i < 2);
        sw  = (w == 1 && i < 2) || (w == 2 && i >= 2);
        apb(1'b1, PGM_IDX_SOURCE_CFG, {2'b00, lin, sw, 4'hF});
        settle();
        apb(1'b0, PGM_IDX_LIVE_STATUS, 8'h00);
        chk(rd[3:0], (w == 1) ? 4'(~(4'h1 << i)) : 4'hF, "window check");
      end
    end
    @(posedge pclk);
    ov_ok <= 4'hF;
    apb(1'b1, PGM_IDX_SOURCE_CFG, 8'h0F);
    clear_all();
  endtask : t_window

  task automatic t_select();
    apb(1'b1, PGM_IDX_SOURCE_CFG, 8'h01);
    set_uv(4'hE);
    chk(pin_level, 1'b0, "selected source bad");
    set_uv(4'h1);
    chk(pin_level, 1'b1, "unselected sources bad");
    apb(1'b1, PGM_IDX_SOURCE_CFG, 8'h0F);
    set_uv(4'h7);
    chk(pin_level, 1'b0, "one of all selected bad");
    set_uv(4'hF);
    clear_all();
  endtask : t_select

  task automatic t_thermal();
    @(posedge pclk);
    thermal_warn <= 1'b1;
    settle();
    chk(pin_level, 1'b1, "warning ignored");
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h05);
    settle();
    chk(pin_level, 1'b0, "warning forces inactive");
    @(posedge pclk);
    thermal_warn <= 1'b0;
    settle();
    chk(pin_level, 1'b1, "warning gone");
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h01);
    clear_all();
  endtask : t_thermal

  task automatic t_fault();
    apb(1'b1, PGM_IDX_IRQ_ENABLE, 8'h01);
    settle();
    chk(irq, 1'b0, "irq idle");
    set_uv(4'h7);
    apb(1'b0, PGM_IDX_FAULT_LATCH, 8'h00);
    chk(rd, 32'h8, "latch set");
    apb(1'b0, PGM_IDX_IRQ_STATUS, 8'h00);
    chk(rd[0], 1'b1, "drop flag set");
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, PGM_IDX_FAULT_LATCH, 8'h08);
    apb(1'b0, PGM_IDX_FAULT_LATCH, 8'h00);
    chk(rd, 32'h8, "clear refused while invalid");
    set_uv(4'hF);
    chk(pin_level, 1'b1, "live status ignores latch");
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h03);
    settle();
    chk(pin_level, 1'b0, "latch gates pin");
    apb(1'b1, PGM_IDX_FAULT_LATCH, 8'h08);
    settle();
    apb(1'b0, PGM_IDX_FAULT_LATCH, 8'h00);
    chk(rd, 32'h0, "latch cleared");
    chk(pin_level, 1'b1, "latch clear restores pin");
    apb(1'b1, PGM_IDX_IRQ_CLEAR, 8'h01);
    apb(1'b0, PGM_IDX_IRQ_STATUS, 8'h00);
    chk(rd[0], 1'b0, "drop flag cleared");
    settle();
    chk(irq, 1'b0, "irq cleared");
    apb(1'b1, PGM_IDX_IRQ_ENABLE, 8'h00);
    set_uv(4'hB);
    chk(irq, 1'b0, "irq masked");
    apb(1'b0, PGM_IDX_IRQ_STATUS, 8'h00);
    chk(rd[0], 1'b1, "masked drop flag set");
    set_uv(4'hF);
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h01);
    clear_all();
  endtask : t_fault

  task automatic t_gated();
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h00);
    @(posedge pclk);
    regulators_active <= 1'b0;
    settle();
    chk(pin_level, 1'b0, "gated mode, regulators off");
    apb(1'b1, PGM_IDX_MODE_CFG, 8'h01);
    settle();
    chk(pin_level, 1'b1, "continuous mode");
    @(posedge pclk);
    regulators_active <= 1'b1;
  endtask : t_gated

  // Clock enable, irq flags, byte strobe, misalignment and a reset in mid-run
  task automatic t_misc();
    clear_all();
    apb(1'b1, PGM_IDX_IRQ_ENABLE, 8'h06);
    apb(1'b0, PGM_IDX_IRQ_ENABLE, 8'h00);
    chk(rd, 32'h6, "irq enable readback");
    @(posedge pclk);
    ce    <= 1'b0;
    uv_ok <= 4'hD;
    settle();
    chk(pin_level, 1'b1, "state frozen while clock enable low");
    @(posedge pclk);
    ce <= 1'b1;
    settle();
    chk(pin_level, 1'b0, "switcher1 failure after enable");
    apb(1'b0, PGM_IDX_IRQ_STATUS, 8'h00);
    chk(rd, 32'h3, "drop and new fault flags");
    chk(irq, 1'b1, "fault flag raises irq");
    apb(1'b0, PGM_IDX_LIVE_STATUS, 8'h00);
    chk(rd, 32'h0D, "live status with one source bad");
    set_uv(4'hF);
    apb(1'b0, PGM_IDX_IRQ_STATUS, 8'h00);
    chk(rd, 32'h7, "rise flag added");
    @(posedge pclk);
    pstrb <= 4'hE;
    apb(1'b1, PGM_IDX_FAULT_LATCH, 8'h02);
    pstrb <= 4'hF;
    apb(1'b0, PGM_IDX_FAULT_LATCH, 8'h00);
    chk(rd, 32'h2, "clear without byte strobe ignored");
    pofs <= 2'b01;
    apb(1'b1, PGM_IDX_SOURCE_CFG, 8'h00);
    chk({31'h0, err}, 32'h1, "misaligned write error");
    pofs <= 2'b00;
    apb(1'b0, PGM_IDX_SOURCE_CFG, 8'h00);
    chk(rd, 32'h0F, "misaligned write ignored");
    clear_all();
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk(pin_level, 1'b0, "pin inactive in reset");
    presetn <= 1'b1;
    apb(1'b0, PGM_IDX_SOURCE_CFG, 8'h00);
    chk(rd, 32'h0, "source cfg after second reset");
    apb(1'b0, PGM_IDX_FAULT_LATCH, 8'h00);
    chk(rd, 32'h0, "fault latch after second reset");
  endtask : t_misc

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pin();
    t_window();
    t_select();
    t_thermal();
    t_fault();
    t_gated();
    t_misc();
    conclude();
  end
endmodule : power_good_monitor_test
